// ---- hw/based_load_store_unit.sv ----
// Base-relative load/store and test-and-set execution unit.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`include "bls_consts.svh"

// What this block does
// R1: Target address is base register plus signed 16-bit operation constant.
// R2: Base register is 20 bits, usable without touching the accumulators.
// R3: Constant is sign-extended and added in 20 bits before range checks.
// R4: Local loads fill accumulator one, old value moves to accumulator two.
// R5: Local address above top of local area raises transfer error, handler.
// R6: Without handler, unit stops and records error code in interrupt stack.
// R7: Test-and-set writes own slot id into low byte if it reads zero.
// R8: Test-and-set read and write are one locked, uninterruptible sequence.
// R9: Condition codes: 00 claimed, 10 already own, 01 other owner.
// R10: Test-and-set accepts only global area addresses, else transfer error.
// R11: Other processors claim shared areas only through test-and-set.
// R12: Holder releases a shared area by writing zero to its location.
// R13: Byte-organized loads zero unused upper bits, old acc one to acc two.
// R14: Byte-organized stores write lowest byte, low half or whole acc one.
// R15: Byte-organized top limit depends on size; outside raises error.
// R16: Word-organized loads zero upper half for words, copy old acc one.
// R17: Word-organized range starts at global base with size-based top.
// R18: Word-organized range error puts error id into accumulator one.
module based_load_store_unit
  import bls_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic [1:0] mem_size,
  output logic [19:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic mem_lock,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic handler_call,
  output logic stop_state,
  output logic cond_code_high,
  output logic cond_code_low
);

  // ==========================================================
  // State and storage.
  seq_state_e state_ff;
  op_e op_ff;
  logic [19:0] base_address_reg_ff;
  logic [31:0] acc_one_ff;
  logic [31:0] acc_two_ff;
  logic [7:0] slot_id_ff;
  logic handler_loaded_ff;
  logic [15:0] interrupt_stack_ff;
  logic transfer_error_ff;
  logic cc_high_ff;
  logic cc_low_ff;
  logic handler_call_ff;
  logic req_ff;
  logic we_ff;
  logic lock_ff;
  logic [1:0] size_ff;
  logic [19:0] addr_ff;
  logic [31:0] wdata_ff;
  logic [31:0] rdata_ff;

  logic [19:0] eff_addr;
  logic range_err;
  op_e cmd_op;
  logic start;
  logic done_ack;
  logic err_start;
  logic is_load;
  logic is_wordorg;
  logic [1:0] nxt_size;
  logic [31:0] nxt_store;
  logic [31:0] nxt_load;
  logic tas_free;
  logic tas_own;

  assign cmd_op = op_e'(reg_wdata[`CMD_OP_MSB:`CMD_OP_LSB]);
  // A command is refused while an access is in flight or stopped.
  assign start = reg_wr && (reg_addr == `REG_CMD) && state_ff[0];
  assign err_start = start && range_err;
  assign done_ack = state_ff[1] && mem_ack;

  // R1: address from base plus operation constant.
  bls_addr_check u_addr (
    .base_addr(base_address_reg_ff),
    .offset(reg_wdata[`CMD_CONST_MSB:0]),
    .op(reg_wdata[`CMD_OP_MSB:`CMD_OP_LSB]),
    .eff_addr(eff_addr),
    .range_err(range_err)
  );

  // ==========================================================
  // Operation decode for the incoming command.
  always_comb begin
    nxt_size = sz_dword;
    nxt_store = acc_one_ff;
    unique case (cmd_op)
      local_load_word, local_store_word, byteorg_load_word,
      byteorg_store_word, wordorg_load_word, wordorg_store_word,
      global_test_and_set: begin
        nxt_size = sz_word;
        nxt_store = {16'h0000, acc_one_ff[15:0]};
      end
      byteorg_load_byte, byteorg_store_byte: begin
        nxt_size = sz_byte;
        nxt_store = {24'h000000, acc_one_ff[7:0]};
      end
      default: begin
        nxt_size = sz_dword;
        nxt_store = acc_one_ff;
      end
    endcase
  end

  assign is_wordorg = (cmd_op == wordorg_load_word) ||
                      (cmd_op == wordorg_load_dword) ||
                      (cmd_op == wordorg_store_word) ||
                      (cmd_op == wordorg_store_dword);
  assign is_load = (op_ff == local_load_word) ||
                   (op_ff == local_load_dword) ||
                   (op_ff == byteorg_load_byte) ||
                   (op_ff == byteorg_load_word) ||
                   (op_ff == byteorg_load_dword) ||
                   (op_ff == wordorg_load_word) ||
                   (op_ff == wordorg_load_dword);
  assign tas_free = (mem_rdata[7:0] == 8'h00);
  assign tas_own = (mem_rdata[7:0] == slot_id_ff);

  // Load data shaping per operation.
  always_comb begin
    nxt_load = mem_rdata;
    unique case (op_ff)
      // R4: word load keeps the high half.
      local_load_word: nxt_load = {acc_one_ff[31:16], mem_rdata[15:0]};
      // R13: byte load zeroes upper bits.
      byteorg_load_byte: nxt_load = {24'h000000, mem_rdata[7:0]};
      // R16: word loads zero the high half.
      byteorg_load_word, wordorg_load_word: begin
        nxt_load = {16'h0000, mem_rdata[15:0]};
      end
      default: nxt_load = mem_rdata;
    endcase
  end

  // ==========================================================
  // Sequencer. Stop is left only by a software restart.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= st_idle;
      op_ff <= local_load_word;
    end else begin
      unique case (state_ff)
        st_idle: begin
          if (start) begin
            op_ff <= cmd_op;
            // R6: no handler means stop.
            if (range_err && !handler_loaded_ff) begin
              state_ff <= st_stop;
            end else if (!range_err) begin
              state_ff <= st_access;
            end
          end
        end
        st_access: begin
          if (mem_ack) begin
            // R7: free location gets claimed.
            if (op_ff == global_test_and_set && tas_free) begin
              state_ff <= st_tas_wr;
            end else begin
              state_ff <= st_idle;
            end
          end
        end
        st_tas_wr: begin
          if (mem_ack) begin
            state_ff <= st_idle;
          end
        end
        st_stop: begin
          if (reg_wr && reg_addr == `REG_STATUS && reg_wdata[`ST_STOP]) begin
            state_ff <= st_idle;
          end
        end
        default: begin
          state_ff <= st_idle;
        end
      endcase
    end
  end

  // ==========================================================
  // Memory port. Request holds until acknowledged.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      lock_ff <= 1'b0;
      size_ff <= sz_byte;
      addr_ff <= 20'h00000;
      wdata_ff <= 32'h0000_0000;
    end else if (start && !range_err) begin
      req_ff <= 1'b1;
      // R14: store data from accumulator one.
      we_ff <= (cmd_op == local_store_word) ||
               (cmd_op == local_store_dword) ||
               (cmd_op == byteorg_store_byte) ||
               (cmd_op == byteorg_store_word) ||
               (cmd_op == byteorg_store_dword) ||
               (cmd_op == wordorg_store_word) ||
               (cmd_op == wordorg_store_dword);
      // R8: bus locked from the test read on.
      lock_ff <= (cmd_op == global_test_and_set);
      size_ff <= nxt_size;
      addr_ff <= eff_addr;
      wdata_ff <= nxt_store;
    end else if (done_ack && op_ff == global_test_and_set && tas_free) begin
      // R7: write own slot id, keep high byte.
      we_ff <= 1'b1;
      wdata_ff <= {16'h0000, mem_rdata[15:8], slot_id_ff};
    end else if (mem_ack) begin
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      lock_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Accumulators. Unit updates win over a same-cycle bus write.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_one_ff <= 32'h0000_0000;
      acc_two_ff <= 32'h0000_0000;
    end else if (err_start && is_wordorg) begin
      // R18: error id for the handler.
      acc_one_ff <= `WORDORG_ERR_ID;
    end else if (done_ack && is_load) begin
      // R4: old accumulator one moves down.
      acc_two_ff <= acc_one_ff;
      acc_one_ff <= nxt_load;
    end else if (reg_wr && reg_addr == `REG_ACC1) begin
      acc_one_ff <= reg_wdata;
    end else if (reg_wr && reg_addr == `REG_ACC2) begin
      acc_two_ff <= reg_wdata;
    end
  end

  // ==========================================================
  // Base register and configuration.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      base_address_reg_ff <= `BASE_RESET;
      slot_id_ff <= 8'h00;
      handler_loaded_ff <= 1'b0;
    end else if (reg_wr) begin
      // R2: full 20-bit base, no accumulator involved.
      if (reg_addr == `REG_BASE) begin
        base_address_reg_ff <= reg_wdata[19:0];
      end
      if (reg_addr == `REG_CONFIG) begin
        slot_id_ff <= reg_wdata[7:0];
        handler_loaded_ff <= reg_wdata[`CFG_HANDLER];
      end
    end
  end

  // ==========================================================
  // Error flag, handler call, interrupt stack and condition codes.
  // The sticky error flag is set in preference to a software clear.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      transfer_error_ff <= 1'b0;
      handler_call_ff <= 1'b0;
      interrupt_stack_ff <= 16'h0000;
    end else begin
      // R5: range error raises the handler.
      handler_call_ff <= err_start && handler_loaded_ff;
      if (err_start) begin
        transfer_error_ff <= 1'b1;
      end else if (reg_wr && reg_addr == `REG_STATUS &&
                   reg_wdata[`ST_TERR]) begin
        transfer_error_ff <= 1'b0;
      end
      // R6: error code stacked on stop.
      if (err_start && !handler_loaded_ff) begin
        interrupt_stack_ff <= `TERR_STACK_CODE;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cc_high_ff <= 1'b0;
      cc_low_ff <= 1'b0;
    end else if (done_ack && op_ff == global_test_and_set) begin
      // R9: result of the test.
      cc_high_ff <= !tas_free && tas_own;
      cc_low_ff <= !tas_free && !tas_own;
    end
  end

  // ==========================================================
  // Register read port, data one cycle after the strobe.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `REG_BASE: rdata_ff <= {12'h000, base_address_reg_ff};
        `REG_ACC1: rdata_ff <= acc_one_ff;
        `REG_ACC2: rdata_ff <= acc_two_ff;
        `REG_STATUS: rdata_ff <= {27'h0, state_ff[3],
          transfer_error_ff, cc_high_ff, cc_low_ff, !state_ff[0]};
        `REG_CONFIG: rdata_ff <= {23'h0, handler_loaded_ff,
          slot_id_ff};
        `REG_INT_STACK: rdata_ff <= {16'h0000, interrupt_stack_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_ff;
  assign mem_req = req_ff;
  assign mem_we = we_ff;
  assign mem_size = size_ff;
  assign mem_addr = addr_ff;
  assign mem_wdata = wdata_ff;
  assign mem_lock = lock_ff;
  assign handler_call = handler_call_ff;
  assign stop_state = state_ff[3];
  assign cond_code_high = cc_high_ff;
  assign cond_code_low = cc_low_ff;

  // ==========================================================
  // Checks.
  a_addr_sum: assert property (@(posedge core_clk) disable iff (!rst_b) // R1
    start && !range_err |=> mem_addr == $past(base_address_reg_ff) +
      {{4{$past(reg_wdata[15])}}, $past(reg_wdata[15:0])})
    else $error("Effective address is not base plus constant.");
  a_lock_held: assert property (@(posedge core_clk) disable iff (!rst_b) // R8
    state_ff == st_tas_wr |-> mem_lock && mem_req && mem_we)
    else $error("Test-and-set write left the bus unlocked.");
  a_slot_write: assert property (@(posedge core_clk) disable iff (!rst_b) // R7
    done_ack && op_ff == global_test_and_set && tas_free
    |=> mem_wdata[7:0] == slot_id_ff ##1 1'b1)
    else $error("Claimed location does not get own slot id.");
  a_cc_other: assert property (@(posedge core_clk) disable iff (!rst_b) // R9
    done_ack && op_ff == global_test_and_set && !tas_free && !tas_own
    |=> !cond_code_high && cond_code_low)
    else $error("Foreign owner not reported in condition codes.");
  a_stop_stack: assert property (@(posedge core_clk) disable iff (!rst_b) // R6
    err_start && !handler_loaded_ff
    |=> stop_state && interrupt_stack_ff == `TERR_STACK_CODE)
    else $error("Unhandled transfer error did not stop the unit.");
  a_local_top: assert property (@(posedge core_clk) disable iff (!rst_b) // R5
    start && cmd_op == local_load_word && eff_addr > `LOCAL_TOP
    |=> transfer_error_ff && !mem_req)
    else $error("Local access above local top was not refused.");
  a_err_id: assert property (@(posedge core_clk) disable iff (!rst_b) // R18
    err_start && is_wordorg |=> acc_one_ff == `WORDORG_ERR_ID)
    else $error("Word-organized range error left no error id.");
  a_acc_copy: assert property (@(posedge core_clk) disable iff (!rst_b) // R4
    done_ack && is_load |=> acc_two_ff == $past(acc_one_ff))
    else $error("Load did not move accumulator one down.");
  a_byte_zero: assert property (@(posedge core_clk) disable iff (!rst_b) // R13
    done_ack && op_ff == byteorg_load_byte
    |=> acc_one_ff[31:8] == 24'h000000)
    else $error("Byte load left upper accumulator bits set.");

endmodule

// ---- hw/bls_addr_check.sv ----
// Effective address adder and per-operation range check.
`timescale 1ns/1ps
`include "bls_consts.svh"

module bls_addr_check
  import bls_pkg::*;
(
  input wire logic [19:0] base_addr,
  input wire logic [15:0] offset,
  input wire logic [3:0] op,
  output logic [19:0] eff_addr,
  output logic range_err
);

  // ==========================================================
  // Address formation.
  // R3: sign extend, then add.
  // The sum wraps at 20 bits, so a negative result lands high.
  always_comb begin
    eff_addr = base_addr + {{4{offset[15]}}, offset};
  end

  // ==========================================================
  // Range check, done on the wrapped 20-bit sum.
  always_comb begin
    range_err = 1'b1;
    unique case (op_e'(op))
      // R5: local area limit.
      local_load_word, local_load_dword,
      local_store_word, local_store_dword: begin
        range_err = eff_addr > `LOCAL_TOP;
      end
      // R10/R15/R17: global area for test-and-set, byte and word-organized word ops.
      global_test_and_set, byteorg_load_byte, byteorg_store_byte,
      wordorg_load_word, wordorg_store_word: begin
        range_err = eff_addr < `GLOBAL_LOW;
      end
      // R15: word limit by size.
      byteorg_load_word, byteorg_store_word: begin
        range_err = (eff_addr < `GLOBAL_LOW) ||
                    (eff_addr > `GLOBAL_TOP_WORD);
      end
      byteorg_load_dword, byteorg_store_dword: begin
        range_err = (eff_addr < `GLOBAL_LOW) ||
                    (eff_addr > `GLOBAL_TOP_DWORD);
      end
      // R17: word-organized double limit.
      wordorg_load_dword, wordorg_store_dword: begin
        range_err = (eff_addr < `GLOBAL_LOW) ||
                    (eff_addr > `GLOBAL_TOP_WORD);
      end
      default: begin
        range_err = 1'b1;
      end
    endcase
  end

endmodule

// ---- shared/bls_consts.svh ----
// Offsets, field positions, limits and codes of the load/store unit.
`ifndef BLS_CONSTS_SVH
`define BLS_CONSTS_SVH

// ==========================================================
// Register indices on the plain register port.
`define REG_BASE 4'h0
`define REG_CMD 4'h1
`define REG_ACC1 4'h2
`define REG_ACC2 4'h3
`define REG_STATUS 4'h4
`define REG_CONFIG 4'h5
`define REG_INT_STACK 4'h6

// ==========================================================
// Command word fields.
`define CMD_OP_MSB 19
`define CMD_OP_LSB 16
`define CMD_CONST_MSB 15

// Status word bit positions.
`define ST_BUSY 0
`define ST_CC_LOW 1
`define ST_CC_HIGH 2
`define ST_TERR 3
`define ST_STOP 4

// Config word fields.
`define CFG_HANDLER 8

// ==========================================================
// Address limits, inclusive.
`define LOCAL_TOP 20'heffff
`define GLOBAL_LOW 20'hf0000
`define GLOBAL_TOP_BYTE 20'hfffff
`define GLOBAL_TOP_WORD 20'hffffe
`define GLOBAL_TOP_DWORD 20'hffffc

// ==========================================================
// Codes and reset values.
`define WORDORG_ERR_ID 32'h0000_1a01
`define TERR_STACK_CODE 16'h0020
`define BASE_RESET 20'h00000

`endif

// ---- shared/bls_pkg.sv ----
// Types shared by the load/store unit files.
package bls_pkg;

  // Operations of the unit, as carried in the command word.
  typedef enum logic [3:0] {
    local_load_word = 4'h0,
    local_load_dword = 4'h1,
    local_store_word = 4'h2,
    local_store_dword = 4'h3,
    global_test_and_set = 4'h4,
    byteorg_load_byte = 4'h5,
    byteorg_load_word = 4'h6,
    byteorg_load_dword = 4'h7,
    byteorg_store_byte = 4'h8,
    byteorg_store_word = 4'h9,
    byteorg_store_dword = 4'ha,
    wordorg_load_word = 4'hb,
    wordorg_load_dword = 4'hc,
    wordorg_store_word = 4'hd,
    wordorg_store_dword = 4'he
  } op_e;

  // Access width on the memory port.
  typedef enum logic [1:0] {
    sz_byte = 2'h0,
    sz_word = 2'h1,
    sz_dword = 2'h2
  } size_e;

  // Sequencer states.
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_access = 4'b0010,
    st_tas_wr = 4'b0100,
    st_stop = 4'b1000
  } seq_state_e;

endpackage

// ---- tb/bls_mem_model.sv ----
// Behavioural memory that answers the unit's memory port.
`timescale 1ns/1ps

module bls_mem_model
  import bls_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [2:0] ack_delay,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_size,
  input wire logic [19:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:255];
  logic [2:0] wait_ff;
  logic go;

  // ==========================================================
  // Storage, aliased on the low address byte to keep the model small.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 32'h8d7c_6b00 | i;
    end
  end
  assign go = mem_req && !mem_ack && (wait_ff >= ack_delay);

  // Acknowledge after the chosen wait; a pulse, only while requested.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      wait_ff <= 3'h0;
    end else if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      wait_ff <= 3'h0;
    end else if (go) begin
      mem_ack <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 3'h1;
    end
  end

  // Read data is only valid with the acknowledge; otherwise it toggles,
  // so a unit that samples late sees garbage rather than a lucky value.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      mem_rdata <= 32'h0f0f_0f0f;
    end else if (go && !mem_we) begin
      mem_rdata <= mem[mem_addr[7:0]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_req && mem_ack && mem_we) begin
      case (mem_size)
        sz_byte: mem[mem_addr[7:0]][7:0] <= mem_wdata[7:0];
        sz_word: mem[mem_addr[7:0]][15:0] <= mem_wdata[15:0];
        default: mem[mem_addr[7:0]] <= mem_wdata;
      endcase
    end
  end
endmodule

// ---- tb/tb_based_load_store_unit.sv ----
// Self-checking bench for the based load/store unit.
`timescale 1ns/1ps
`include "bls_consts.svh"

module tb_based_load_store_unit
  import bls_pkg::*;
;
  typedef struct packed {op_e op; logic [19:0] b; logic [15:0] o;
    logic e;} row_s;
  logic core_clk, rst_b, reg_wr, reg_rd, mem_req, mem_we, mem_lock, mem_ack;
  logic handler_call, stop_state, cond_code_high, cond_code_low, lock_q;
  logic last_we, last_lock, ok;
  logic [3:0] reg_addr;
  logic [2:0] ack_delay;
  logic [1:0] mem_size;
  logic [19:0] mem_addr, last_addr, eff;
  logic [31:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata, s, w, acc, a1, a2;
  int mismatches = 0, checks = 0, calls = 0, lock_edges = 0, n0, e0;
  row_s r;
  row_s rows [0:17] = '{
    '{local_load_word, 20'h00010, 16'h0005, 1'b0},
    '{local_load_dword, 20'heffff, 16'h0000, 1'b0},
    '{local_store_word, 20'heffff, 16'h0001, 1'b1},
    '{local_store_dword, 20'h00000, 16'hff00, 1'b1},
    '{local_store_word, 20'h00100, 16'hff00, 1'b0},
    '{byteorg_load_byte, 20'hf0000, 16'h0010, 1'b0},
    '{byteorg_load_word, 20'hf0010, 16'hffee, 1'b1},
    '{byteorg_load_dword, 20'hfff00, 16'h00fc, 1'b0},
    '{byteorg_store_byte, 20'hff000, 16'h0fff, 1'b0},
    '{byteorg_store_word, 20'hff000, 16'h0fff, 1'b1},
    '{byteorg_store_dword, 20'hfff00, 16'h00fd, 1'b1},
    '{wordorg_load_word, 20'hff000, 16'h0fff, 1'b0},
    '{wordorg_load_dword, 20'hff000, 16'h0fff, 1'b1},
    '{wordorg_store_word, 20'hf0000, 16'h0020, 1'b0},
    '{wordorg_store_dword, 20'hfff00, 16'h00fe, 1'b0},
    '{byteorg_store_word, 20'hfff00, 16'h00fe, 1'b0},
    '{byteorg_store_dword, 20'hfff00, 16'h00fc, 1'b0},
    '{wordorg_load_dword, 20'hf8000, 16'h7ffe, 1'b0}};

  based_load_store_unit i_based_load_store_unit (.core_clk(core_clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_lock(mem_lock),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .handler_call(handler_call),
    .stop_state(stop_state), .cond_code_high(cond_code_high),
    .cond_code_low(cond_code_low));
  bls_mem_model i_bls_mem_model (.core_clk(core_clk), .rst_b(rst_b),
    .ack_delay(ack_delay), .mem_req(mem_req), .mem_we(mem_we),
    .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ==========================================================
  // Expected behaviour, worked out independently of the unit.
  function automatic logic is_load(op_e op);
    return op inside {local_load_word, local_load_dword, byteorg_load_byte,
      byteorg_load_word, byteorg_load_dword, wordorg_load_word,
      wordorg_load_dword};
  endfunction
  function automatic logic [31:0] exp_load(op_e op, logic [31:0] w,
    logic [31:0] a);
    case (op)
      local_load_word: return {a[31:16], w[15:0]};
      byteorg_load_byte: return {24'h0, w[7:0]};
      byteorg_load_word, wordorg_load_word: return {16'h0, w[15:0]};
      default: return w;
    endcase
  endfunction
  function automatic logic [31:0] merge(op_e op, logic [31:0] w,
    logic [31:0] a);
    case (op)
      byteorg_store_byte: return {w[31:8], a[7:0]};
      local_store_word, byteorg_store_word, wordorg_store_word:
        return {w[31:16], a[15:0]};
      default: return a;
    endcase
  endfunction

  // ==========================================================
  // Bus tasks and the single comparison.
  task automatic chk(input string what, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // Issue one operation and poll status until the unit is idle again.
  task automatic run(input op_e op, input logic [19:0] b,
    input logic [15:0] o, output logic [31:0] st);
    wr(`REG_BASE, {12'h0, b});
    wr(`REG_CMD, {12'h0, op, o});
    st = 32'h1;
    for (int n = 0; n < 30 && st[`ST_BUSY] !== 1'b0; n++) begin
      rd(`REG_STATUS, st);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Monitor of the memory port: last access, lock edges, handler pulses.
  always @(posedge core_clk) begin
    lock_q <= mem_lock;
    if (lock_q !== mem_lock) begin
      lock_edges <= lock_edges + 1;
    end
    if (handler_call === 1'b1) begin
      calls <= calls + 1;
    end
    if (mem_req === 1'b1 && mem_ack === 1'b1) begin
      last_addr <= mem_addr;
      last_we <= mem_we;
      last_lock <= mem_lock;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Watchdog: the whole run needs a few thousand cycles at most.
  initial begin
    #400000;
    mismatches++;
    give_verdict;
  end

  initial begin
    {rst_b, reg_wr, reg_rd} = 3'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    ack_delay = 3'h0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    chk("reset outputs", 32'h0, {26'h0, mem_req, mem_lock, handler_call,
      stop_state, cond_code_high, cond_code_low});
    rd(`REG_ACC1, a1);
    chk("acc one reset", 32'h0, a1);
    $display("reset test done");
    wr(`REG_CONFIG, 32'h13c);
    // Table rows; waits of 0..2 cycles vary the memory's answer.
    foreach (rows[i]) begin
      r = rows[i];
      ack_delay <= 3'(i % 3);
      eff = r.b + {{4{r.o[15]}}, r.o};
      ok = !r.e;
      w = i_bls_mem_model.mem[eff[7:0]];
      acc = 32'h5e6f_7a8b ^ i;
      wr(`REG_ACC1, acc);
      n0 = calls;
      run(r.op, r.b, r.o, s);
      chk("error flag", {31'h0, !ok}, {31'h0, s[`ST_TERR]});
      chk("handler pulses", n0 + !ok, calls);
      rd(`REG_BASE, a1);
      chk("base", {12'h0, r.b}, a1);
      rd(`REG_ACC1, a1);
      rd(`REG_ACC2, a2);
      if (!ok && r.op inside {wordorg_load_dword, wordorg_store_dword}) begin
        chk("error id", `WORDORG_ERR_ID, a1);
      end else if (ok) begin
        chk("address", {12'h0, eff}, {12'h0, last_addr});
        if (is_load(r.op)) begin
          chk("acc one", exp_load(r.op, w, acc), a1);
          chk("acc two", acc, a2);
        end else begin
          chk("stored", merge(r.op, w, acc),
            i_bls_mem_model.mem[eff[7:0]]);
        end
      end
      wr(`REG_STATUS, 32'h8);
      $display("row %0d done", i);
    end
    // Test-and-set: free, own, foreign and out-of-area locations.
    ack_delay <= 3'h2;
    i_bls_mem_model.mem[0] = 32'h1234_5600;
    e0 = lock_edges;
    run(global_test_and_set, 20'hf0000, 16'h0000, s);
    chk("claim cc", 32'h0, {30'h0, cond_code_high, cond_code_low});
    chk("claim word", 32'h1234_563c, i_bls_mem_model.mem[0]);
    chk("write locked", 32'h3, {30'h0, last_we, last_lock});
    chk("lock edges", e0 + 2, lock_edges);
    run(global_test_and_set, 20'hf0100, 16'hff00, s);
    chk("own cc", 32'h2, {30'h0, cond_code_high, cond_code_low});
    chk("own no write", 32'h0, {31'h0, last_we});
    i_bls_mem_model.mem[0] = 32'h0000_0055;
    run(global_test_and_set, 20'hf0000, 16'h0000, s);
    chk("other cc", 32'h1, {30'h0, cond_code_high, cond_code_low});
    chk("other kept", 32'h55, i_bls_mem_model.mem[0]);
    run(global_test_and_set, 20'hf0000, 16'hffff, s);
    chk("tas range", 32'h1, {31'h0, s[`ST_TERR]});
    wr(`REG_STATUS, 32'h8);
    run(op_e'(4'hf), 20'hf0000, 16'h0000, s);
    chk("bad op", 32'h1, {31'h0, s[`ST_TERR]});
    wr(`REG_STATUS, 32'h8);
    wr(`REG_ACC1, 32'h0);
    run(byteorg_store_byte, 20'hf0000, 16'h0000, s);
    chk("released", 32'h0, i_bls_mem_model.mem[0]);
    $display("test-and-set test done");
    // No handler loaded: the unit stops and records the code.
    wr(`REG_CONFIG, 32'h03c);
    n0 = calls;
    run(local_load_word, 20'hf0000, 16'h0000, s);
    chk("stopped", 32'h1, {31'h0, stop_state});
    chk("no handler", n0, calls);
    rd(`REG_INT_STACK, a1);
    chk("stack code", {16'h0, `TERR_STACK_CODE}, a1);
    wr(`REG_STATUS, 32'h18);
    @(negedge core_clk);
    chk("restarted", 32'h0, {31'h0, stop_state});
    $display("stop test done");
    give_verdict;
  end
endmodule
